// file: hw/event_flag_regs.vh
`ifndef EVENT_FLAG_REGS_VH
`define EVENT_FLAG_REGS_VH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define POWER_STATE_EVENT_FLAGS_IDX 16'h4012
`define REGULATOR_UNDERVOLTAGE_FLAGS_IDX 16'h4013
`define CONVERTER_OSCILLATOR_FLAGS_IDX 16'h4014
`define IRQ_CONFIG_IDX 16'h4017
`define SYSTEM_SUMMARY_IDX 16'h4010

// ----------------------------------------
// implemented bit masks
// ----------------------------------------
`define POWER_STATE_MASK 16'h0037
`define REGULATOR_UV_MASK 16'h03FF
`define CONVERTER_OSC_MASK 16'h03CF

// ----------------------------------------
// field positions
// ----------------------------------------
`define MEM_COMMAND_DONE_BIT 5
`define MEM_COMMAND_FAIL_BIT 4
`define POWERUP_RESET_BIT 2
`define ENTER_LOWPOWER_BIT 1
`define ENTER_ACTIVE_BIT 0
`define BUCK_OVERCURRENT_LSB 8
`define OSC_START_FAIL_BIT 7
`define OSC_TAMPER_BIT 6
`define MEM_SUMMARY_BIT 4
`define REQUEST_PIN_MASK_BIT 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define FLAGS_RESET 16'h0000
`define REQUEST_PIN_MASK_RESET 1'b0

`endif

// file: hw/secondary_event_flag_latches.v
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "event_flag_regs.vh"

// Function
// - every flag is sticky and clears only when software writes a one to its bit.
// - power-state bit 5 sets on a rising memory command done indication.
// - power-state bit 4 sets on a rising memory command fail indication.
// - power-state bit 2 sets on a rising power-on reset event.
// - power-state bit 1 sets on a rising entry into sleep or off.
// - power-state bit 0 sets on a rising entry into the on state.
// - regulator register bits 0 to 9 set on rising undervoltage of regulators 1 to 10.
// - converter register bits 8,9 set on rising overcurrent, bits 0 to 3 on rising undervoltage.
// - converter register bit 7 sets on a rising oscillator start failure.
// - converter register bit 6 sets on either edge of the oscillator tamper signal.
// - the three registers sit at indices 4012h to 4014h and reset cleared.
// - the memory summary bit is high while a memory command flag is set.
// - a set request pin mask keeps the interrupt request inactive.
module secondary_event_flag_latches #(
  parameter ADDR_WIDTH = 18
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_WIDTH-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire mem_command_done,
  input wire mem_command_fail,
  input wire powerup_reset_event,
  input wire enter_lowpower,
  input wire enter_active,
  input wire [9:0] linreg_undervolt,
  input wire [1:0] buck_overcurrent,
  input wire [3:0] buck_undervolt,
  input wire osc_start_fail,
  input wire osc_tamper,
  output reg mem_summary,
  output reg irq_request
);

  // ----------------------------------------
  // event synchronisers and edge detect
  // ----------------------------------------
  localparam NEV = 23;

  // ----------------------------------------
  // event slot map
  // ----------------------------------------
  localparam EV_DONE = 0;
  localparam EV_FAIL = 1;
  localparam EV_POR = 2;
  localparam EV_LOWPOWER = 3;
  localparam EV_ACTIVE = 4;
  localparam EV_LINREG = 5;
  localparam EV_BUCK_OC = 15;
  localparam EV_BUCK_UV = 17;
  localparam EV_OSC_START = 21;
  localparam EV_OSC_TAMPER = 22;

  wire [NEV-1:0] ev_raw;
  wire [NEV-1:0] rise;
  wire [NEV-1:0] either;

  assign ev_raw = {osc_tamper, osc_start_fail, buck_undervolt, buck_overcurrent, linreg_undervolt,
                   enter_active, enter_lowpower, powerup_reset_event, mem_command_fail, mem_command_done};

  // two flops against metastability, a third for the edge
  genvar gi;
  generate
    for (gi = 0; gi < NEV; gi = gi + 1) begin : g_event
      reg sync1;
      reg sync2;
      reg sync3;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1 <= 1'b0;
          sync2 <= 1'b0;
          sync3 <= 1'b0;
        end else begin
          sync1 <= ev_raw[gi];
          sync2 <= sync1;
          sync3 <= sync2;
        end
      end
      assign rise[gi] = sync2 & ~sync3;
      assign either[gi] = sync2 ^ sync3;
    end
  endgenerate

  // ----------------------------------------
  // set vectors per register
  // ----------------------------------------
  wire [15:0] set_ps;
  wire [15:0] set_uv;
  wire [15:0] set_co;

  assign set_ps[15:6] = 10'h000;
  assign set_ps[`MEM_COMMAND_DONE_BIT] = rise[EV_DONE];
  assign set_ps[`MEM_COMMAND_FAIL_BIT] = rise[EV_FAIL];
  assign set_ps[3] = 1'b0;
  assign set_ps[`POWERUP_RESET_BIT] = rise[EV_POR];
  assign set_ps[`ENTER_LOWPOWER_BIT] = rise[EV_LOWPOWER];
  assign set_ps[`ENTER_ACTIVE_BIT] = rise[EV_ACTIVE];
  assign set_uv[15:10] = 6'h00;
  assign set_uv[9:0] = rise[EV_LINREG+9:EV_LINREG];
  assign set_co[15:10] = 6'h00;
  assign set_co[`BUCK_OVERCURRENT_LSB+1:`BUCK_OVERCURRENT_LSB] = rise[EV_BUCK_OC+1:EV_BUCK_OC];
  assign set_co[`OSC_START_FAIL_BIT] = rise[EV_OSC_START];
  assign set_co[`OSC_TAMPER_BIT] = either[EV_OSC_TAMPER];
  assign set_co[5:4] = 2'b00;
  assign set_co[3:0] = rise[EV_BUCK_UV+3:EV_BUCK_UV];

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire access;
  wire wr;
  wire sel_ps;
  wire sel_uv;
  wire sel_co;
  wire sel_cfg;
  wire sel_sum;
  wire [ADDR_WIDTH-1:0] a_ps;
  wire [ADDR_WIDTH-1:0] a_uv;
  wire [ADDR_WIDTH-1:0] a_co;
  wire [ADDR_WIDTH-1:0] a_cfg;
  wire [ADDR_WIDTH-1:0] a_sum;

  // byte address is the word index shifted up by two
  assign a_ps = {`POWER_STATE_EVENT_FLAGS_IDX, 2'b00};
  assign a_uv = {`REGULATOR_UNDERVOLTAGE_FLAGS_IDX, 2'b00};
  assign a_co = {`CONVERTER_OSCILLATOR_FLAGS_IDX, 2'b00};
  assign a_cfg = {`IRQ_CONFIG_IDX, 2'b00};
  assign a_sum = {`SYSTEM_SUMMARY_IDX, 2'b00};
  assign access = psel & penable & pready;
  assign wr = access & pwrite;
  assign sel_ps = (paddr == a_ps);
  assign sel_uv = (paddr == a_uv);
  assign sel_co = (paddr == a_co);
  assign sel_cfg = (paddr == a_cfg);
  assign sel_sum = (paddr == a_sum);

  // ----------------------------------------
  // flag registers
  // ----------------------------------------
  reg [15:0] power_state_event_flags;
  reg [15:0] regulator_undervoltage_flags;
  reg [15:0] converter_oscillator_flags;
  reg request_pin_mask;
  wire [15:0] clr_ps;
  wire [15:0] clr_uv;
  wire [15:0] clr_co;
  wire [15:0] next_ps;
  wire [15:0] next_uv;
  wire [15:0] next_co;

  wire we_ps;
  wire we_uv;
  wire we_co;

  assign we_ps = wr & sel_ps;
  assign we_uv = wr & sel_uv;
  assign we_co = wr & sel_co;
  assign clr_ps = we_ps ? pwdata[15:0] : 16'h0000;
  assign clr_uv = we_uv ? pwdata[15:0] : 16'h0000;
  assign clr_co = we_co ? pwdata[15:0] : 16'h0000;
  // set wins over a same-cycle clear
  assign next_ps = ((power_state_event_flags & ~clr_ps) | set_ps) & `POWER_STATE_MASK;
  assign next_uv = ((regulator_undervoltage_flags & ~clr_uv) | set_uv) & `REGULATOR_UV_MASK;
  assign next_co = ((converter_oscillator_flags & ~clr_co) | set_co) & `CONVERTER_OSC_MASK;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_state_event_flags <= `FLAGS_RESET;
    end else begin
      power_state_event_flags <= next_ps;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regulator_undervoltage_flags <= `FLAGS_RESET;
    end else begin
      regulator_undervoltage_flags <= next_uv;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_oscillator_flags <= `FLAGS_RESET;
    end else begin
      converter_oscillator_flags <= next_co;
    end
  end

  // ----------------------------------------
  // request pin mask
  // ----------------------------------------
  wire next_mask;

  // request drops on the same edge as the mask write
  assign next_mask = (wr && sel_cfg) ? pwdata[`REQUEST_PIN_MASK_BIT] : request_pin_mask;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      request_pin_mask <= `REQUEST_PIN_MASK_RESET;
    end else begin
      request_pin_mask <= next_mask;
    end
  end

  // ----------------------------------------
  // summary and request outputs
  // ----------------------------------------
  wire next_summary;
  wire next_irq;
  wire any_pending;

  assign any_pending = (|next_ps) | (|next_uv) | (|next_co);
  assign next_summary = next_ps[`MEM_COMMAND_DONE_BIT] | next_ps[`MEM_COMMAND_FAIL_BIT];
  assign next_irq = ~next_mask & any_pending;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_summary <= 1'b0;
    end else begin
      mem_summary <= next_summary;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_request <= 1'b0;
    end else begin
      irq_request <= next_irq;
    end
  end

  // ----------------------------------------
  // apb answer: one wait state, read data registered
  // ----------------------------------------
  reg [31:0] next_rdata;
  wire mapped;

  assign mapped = sel_ps | sel_uv | sel_co | sel_cfg | sel_sum;

  always @* begin
    next_rdata = 32'h0000_0000;
    if (sel_ps) begin
      next_rdata = {16'h0000, power_state_event_flags};
    end else if (sel_uv) begin
      next_rdata = {16'h0000, regulator_undervoltage_flags};
    end else if (sel_co) begin
      next_rdata = {16'h0000, converter_oscillator_flags};
    end else if (sel_cfg) begin
      next_rdata = {31'h0000_0000, request_pin_mask};
    end else if (sel_sum) begin
      next_rdata = {27'h000_0000, mem_summary, 4'h0};
    end
  end

  wire next_ready;
  wire next_err;
  wire [31:0] next_prdata;

  assign next_ready = psel & penable & ~pready;
  assign next_err = next_ready & ~mapped;
  // data only in the answer cycle of a read
  assign next_prdata = (next_ready & ~pwrite) ? next_rdata : 32'h0000_0000;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= next_ready;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= next_err;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end

endmodule // secondary_event_flag_latches
`default_nettype wire

// file: bench/event_src.sv
`timescale 1ns/1ps
`default_nettype none
// event levels change just after a clock edge
module event_src (
  input wire logic pclk,
  input wire logic [22:0] req,
  output logic [22:0] ev
);
  always @(posedge pclk) ev <= req;
endmodule // event_src
`default_nettype wire

// file: bench/flag_chk_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module flag_chk (
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic mem_command_done, mem_command_fail, mem_summary, irq_request,
  input wire logic [31:0] prdata
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wacc = psel && penable && pready && pwrite;
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("no answer");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("long ready");
  property p_ans; pready |-> $past(psel && penable); endproperty
  a_ans: assert property (p_ans) else $error("stray ready");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("data outside answer");
  property p_done; $rose(mem_command_done) |-> ##[1:3] mem_summary; endproperty
  a_done: assert property (p_done) else $error("done not latched");
  property p_fail; $rose(mem_command_fail) |-> ##[1:3] mem_summary; endproperty
  a_fail: assert property (p_fail) else $error("fail not latched");
  property p_sum; $fell(mem_summary) |-> $past(wacc); endproperty
  a_sum: assert property (p_sum) else $error("summary not sticky");
  property p_irq; $fell(irq_request) |-> $past(wacc); endproperty
  a_irq: assert property (p_irq) else $error("request not sticky");
  c_err: cover property (pslverr);
  c_sum: cover property ($fell(mem_summary));
  c_irq: cover property ($fell(irq_request));
endmodule // flag_chk
bind secondary_event_flag_latches flag_chk i_chk (.*);
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, mem_summary, irq_request, err_q;
  logic [17:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd_q;
  logic [22:0] req = 0, ev;
  int failures = 0, check_count = 0;
  localparam logic [17:0] PS = 18'h10048, RU = 18'h1004C, CO = 18'h10050, MK = 18'h1005C;
  always #20 pclk = ~pclk;
  event_src i_src (.pclk(pclk), .req(req), .ev(ev));
  secondary_event_flag_latches i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_command_done(ev[22]), .mem_command_fail(ev[21]), .powerup_reset_event(ev[20]),
    .enter_lowpower(ev[19]), .enter_active(ev[18]), .linreg_undervolt(ev[17:8]),
    .buck_overcurrent(ev[7:6]), .buck_undervolt(ev[5:2]), .osc_start_fail(ev[1]), .osc_tamper(ev[0]),
    .mem_summary(mem_summary), .irq_request(irq_request));
  task results;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      failures++;
      results;
    end
    rd_q = prdata;
    err_q = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task rdchk(input logic [17:0] a, input logic [31:0] exp);
    apb(0, a, 0);
    chk(rd_q, exp);
  endtask
  task wait8;
    repeat (8) @(posedge pclk);
  endtask
  task pulse(input logic [22:0] m);
    req <= m;
    repeat (2) @(posedge pclk);
    req <= 0;
    wait8;
  endtask
  task t_power;
    rdchk(PS, 32'h0);
    pulse(23'h540000);
    rdchk(PS, 32'h25);
    chk(mem_summary, 1);
    chk(err_q, 0);
    rdchk(18'h10040, 32'h10);
    apb(1, PS, 32'h05);
    rdchk(PS, 32'h20);
    apb(1, PS, 32'h20);
    chk(mem_summary, 0);
    pulse(23'h280000);
    rdchk(PS, 32'h12);
    apb(1, PS, 32'hFFFF);
    rdchk(PS, 32'h0);
    $display("t_power done");
  endtask
  task t_regs;
    rdchk(RU, 32'h0);
    pulse(23'h015500);
    rdchk(RU, 32'h155);
    pulse(23'h02AA00);
    rdchk(RU, 32'h3FF);
    pulse(23'h000096);
    rdchk(CO, 32'h285);
    pulse(23'h000068);
    rdchk(CO, 32'h38F);
    apb(1, RU, 32'hFFFF);
    apb(1, CO, 32'hFFFF);
    rdchk(CO, 32'h0);
    $display("t_regs done");
  endtask
  task t_edge;
    req <= 23'h040001;
    wait8;
    rdchk(CO, 32'h40);
    apb(1, CO, 32'h40);
    apb(1, PS, 32'h01);
    wait8;
    rdchk(PS, 32'h0);
    req <= 0;
    wait8;
    rdchk(CO, 32'h40);
    chk(irq_request, 1);
    apb(1, MK, 32'h1);
    chk(irq_request, 0);
    rdchk(MK, 32'h1);
    apb(1, MK, 32'h0);
    apb(0, 18'h10060, 0);
    chk(err_q, 1);
    apb(1, CO, 32'h40);
    chk(irq_request, 0);
    $display("t_edge done");
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_power;
    t_regs;
    t_edge;
    results;
  end
endmodule // tb
`default_nettype wire
